// File: hdl/ebs_params.svh
`ifndef EBS_PARAMS_SVH
`define EBS_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define EBS_OFS_CTRL 8'h00
`define EBS_OFS_CMD 8'h04
`define EBS_OFS_STATUS 8'h08
`define EBS_OFS_CONFIG 8'h0c

// ****************************************************************
// Control fields
// ****************************************************************
`define EBS_CTRL_W 6
`define EBS_CTRL_LOW_BYTE_MODE 0
`define EBS_CTRL_BUS_8BIT 1
`define EBS_CTRL_WAIT_EN 2
`define EBS_CTRL_MUX_MODE 3
`define EBS_CTRL_RSTIND_SOFT 4
`define EBS_CTRL_RSTIND_END_RESET 5
`define EBS_CTRL_RESET 6'h08

// ****************************************************************
// Command and status fields
// ****************************************************************
`define EBS_CMD_RSTIND_RELEASE 0
`define EBS_STATUS_RSTIND 0
`define EBS_STATUS_BOOT_EXT 1
`define EBS_STATUS_BUSY 2
`define EBS_STATUS_PINS_LSB 3
`define EBS_STATUS_PINS_MSB 5

// ****************************************************************
// Pin config sampled at reset: read strobe, latch, write strobe
// ****************************************************************
`define EBS_PIN_RD 0
`define EBS_PIN_ALE 1
`define EBS_PIN_WR 2

`endif

// File: hdl/ebs_pkg.sv
`default_nettype none

package ebs_pkg;

  // ****************************************************************
  // External cycle phases
  // ****************************************************************
  typedef enum logic [1:0] {
    EBS_IDLE = 2'b00,
    EBS_ADDR = 2'b01,
    EBS_STROBE = 2'b10,
    EBS_END = 2'b11
  } ebs_state_e;

endpackage : ebs_pkg

`default_nettype wire

// File: hdl/ebs_strobe_sel.sv
`default_nettype none

module ebs_strobe_sel (
  // Mode
  input wire logic low_byte_mode,
  input wire logic bus_8bit,
  // Access
  input wire logic is_write,
  input wire logic is_fetch,
  input wire logic [1:0] byte_en,
  // Decision
  output logic read_active,
  output logic write_active
);

  wire low_byte_write;
  wire any_write;

  // Instruction fetches are always reads.
  assign any_write = is_write & ~is_fetch;
  assign low_byte_write = any_write & byte_en[0];

  assign read_active = ~any_write; // R1
  assign write_active = low_byte_mode ? (bus_8bit ? any_write : low_byte_write) // R3
                                      : any_write; // R2

endmodule : ebs_strobe_sel

`default_nettype wire

// File: hdl/ebs_bus_ctrl.sv
// Summary of operation
// R1: Read strobe goes active for every external instruction fetch or data read.
// R2: In single-strobe mode the write strobe fires on every data write, any width.
// R3: Low-byte mode strobes only low-byte writes on 16-bit bus, every write on 8-bit.
// R4: With wait enabled, the far side holds the wait input to stretch the strobe phase.
// R5: Multiplexed modes give an address latch pulse before the data phase.
// R6: Boot select low at reset: config from mux port and read pin, fetch external.
// R7: Boot select high: config from read, latch and write pins, run internal memory.
// R8: Eight segment address outputs carry address bits 23..16, LSB at index 0.
// R9: Hardware reset drives the reset indicator active.
// R10: Optionally a software or watchdog reset drives the reset indicator active.
// R11: Indicator released by init-end instruction, optionally at reset end, or by software.
`default_nettype none
`include "ebs_params.svh"

module ebs_bus_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Core access request
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic [1:0] acc_byte_en,
  input wire logic [23:0] acc_addr,
  output logic acc_busy,
  output logic acc_done,
  // Core reset events
  input wire logic soft_reset_event,
  input wire logic watchdog_reset_event,
  input wire logic init_end_instruction,
  // External bus control pins
  output logic read_strobe_n,
  output logic low_byte_store_strobe_n,
  output logic address_latch,
  input wire logic bus_ready_n,
  output logic [7:0] segment_address_port,
  // Boot configuration pins
  input wire logic boot_fetch_select,
  input wire logic [15:0] multiplexed_bus_port_zero,
  input wire logic [2:0] bus_control_port,
  // Boot configuration results
  output logic boot_external,
  output logic [15:0] start_config,
  output logic [2:0] start_pin_config,
  // Reset indication
  output logic reset_indicator_output_n
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  ebs_pkg::ebs_state_e state;
  ebs_pkg::ebs_state_e next_state;
  logic [`EBS_CTRL_W-1:0] ctrl;
  logic cfg_pending;
  logic cur_write;
  logic cur_fetch;
  logic [1:0] cur_byte_en;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire sel_ctrl = (reg_addr == ADDR_W'(`EBS_OFS_CTRL));
  wire sel_cmd = (reg_addr == ADDR_W'(`EBS_OFS_CMD));
  wire sel_status = (reg_addr == ADDR_W'(`EBS_OFS_STATUS));
  wire sel_config = (reg_addr == ADDR_W'(`EBS_OFS_CONFIG));
  wire ctrl_wr = reg_write & sel_ctrl;
  wire soft_release = reg_write & sel_cmd & reg_wdata[`EBS_CMD_RSTIND_RELEASE];

  wire low_byte_mode = ctrl[`EBS_CTRL_LOW_BYTE_MODE];
  wire bus_8bit = ctrl[`EBS_CTRL_BUS_8BIT];
  wire wait_en = ctrl[`EBS_CTRL_WAIT_EN];
  wire mux_mode = ctrl[`EBS_CTRL_MUX_MODE];
  wire rstind_soft = ctrl[`EBS_CTRL_RSTIND_SOFT];
  wire rstind_end_reset = ctrl[`EBS_CTRL_RSTIND_END_RESET];

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[`EBS_STATUS_RSTIND] = ~reset_indicator_output_n;
    status_word[`EBS_STATUS_BOOT_EXT] = boot_external;
    status_word[`EBS_STATUS_BUSY] = acc_busy;
    status_word[`EBS_STATUS_PINS_MSB:`EBS_STATUS_PINS_LSB] = start_pin_config;
  end

  wire [31:0] next_rdata = ~reg_read ? 32'h0 :
                           sel_ctrl ? {{(32-`EBS_CTRL_W){1'b0}}, ctrl} :
                           sel_status ? status_word :
                           sel_config ? {16'h0, start_config} :
                           32'h0;

  // ****************************************************************
  // Strobe selection
  // ****************************************************************
  logic read_active;
  logic write_active;

  ebs_strobe_sel u_strobe_sel (
    .low_byte_mode(low_byte_mode),
    .bus_8bit(bus_8bit),
    .is_write(cur_write),
    .is_fetch(cur_fetch),
    .byte_en(cur_byte_en),
    .read_active(read_active),
    .write_active(write_active)
  );

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  wire take_req = acc_req & (state == ebs_pkg::EBS_IDLE);
  wire strobe_release = ~wait_en | ~bus_ready_n; // R4

  always_comb begin
    case (state)
      ebs_pkg::EBS_IDLE: begin
        next_state = acc_req ? ebs_pkg::EBS_ADDR : ebs_pkg::EBS_IDLE;
      end
      ebs_pkg::EBS_ADDR: begin
        next_state = ebs_pkg::EBS_STROBE;
      end
      ebs_pkg::EBS_STROBE: begin
        next_state = strobe_release ? ebs_pkg::EBS_END : ebs_pkg::EBS_STROBE; // R4
      end
      ebs_pkg::EBS_END: begin
        next_state = ebs_pkg::EBS_IDLE;
      end
      default: begin
        next_state = ebs_pkg::EBS_IDLE;
      end
    endcase
  end

  wire in_strobe_next = (next_state == ebs_pkg::EBS_STROBE);
  wire next_address_latch = take_req & mux_mode; // R5
  wire next_read_n = ~(in_strobe_next & read_active); // R1
  wire next_write_n = ~(in_strobe_next & write_active); // R2 R3
  wire next_busy = (next_state != ebs_pkg::EBS_IDLE);
  wire next_done = (state == ebs_pkg::EBS_END);

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ebs_pkg::EBS_IDLE;
      cur_write <= 1'b0;
      cur_fetch <= 1'b0;
      cur_byte_en <= 2'h0;
      segment_address_port <= 8'h00;
    end else begin
      state <= next_state;
      if (take_req) begin
        cur_write <= acc_write;
        cur_fetch <= acc_fetch;
        cur_byte_en <= acc_byte_en;
        segment_address_port <= acc_addr[23:16]; // R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      read_strobe_n <= 1'b1;
      low_byte_store_strobe_n <= 1'b1;
      address_latch <= 1'b0;
      acc_busy <= 1'b0;
      acc_done <= 1'b0;
    end else begin
      read_strobe_n <= next_read_n;
      low_byte_store_strobe_n <= next_write_n;
      address_latch <= next_address_latch;
      acc_busy <= next_busy;
      acc_done <= next_done;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= `EBS_CTRL_RESET;
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= next_rdata;
      if (ctrl_wr) begin
        ctrl <= reg_wdata[`EBS_CTRL_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Boot configuration capture
  // ****************************************************************
  // The pins are caught in the first cycle after reset is released,
  // so that the flops under reset only ever load constants.
  wire [2:0] pins_ext_boot = {2'b00, bus_control_port[`EBS_PIN_RD]};
  wire [15:0] next_start_config = boot_fetch_select ? 16'h0000 : multiplexed_bus_port_zero; // R6 R7
  wire [2:0] next_pin_config = boot_fetch_select ? bus_control_port : pins_ext_boot; // R6 R7

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_pending <= 1'b1;
      boot_external <= 1'b0;
      start_config <= 16'h0000;
      start_pin_config <= 3'h0;
    end else begin
      cfg_pending <= 1'b0;
      if (cfg_pending) begin
        boot_external <= ~boot_fetch_select; // R6 R7
        start_config <= next_start_config;
        start_pin_config <= next_pin_config;
      end
    end
  end

  // ****************************************************************
  // Reset indication
  // ****************************************************************
  // A soft or watchdog reset lasts one cycle, so the cycle after it is its end.
  logic int_reset_d;
  wire int_reset = soft_reset_event | watchdog_reset_event;
  wire int_reset_end = int_reset_d & ~int_reset;
  wire reset_end = cfg_pending | int_reset_end;
  // An activation in the same cycle as a release keeps the output active.
  wire rstind_set = rstind_soft & int_reset; // R10
  wire rstind_clear = init_end_instruction | soft_release | (rstind_end_reset & reset_end); // R11
  wire next_rstind_n = rstind_set ? 1'b0 : (rstind_clear ? 1'b1 : reset_indicator_output_n);

  always_ff @(posedge clk) begin
    if (reset) begin
      reset_indicator_output_n <= 1'b0; // R9
      int_reset_d <= 1'b0;
    end else begin
      reset_indicator_output_n <= next_rstind_n; // R10 R11
      int_reset_d <= int_reset;
    end
  end

endmodule : ebs_bus_ctrl

`default_nettype wire

// File: tb/ebs_assertions.sv
`default_nettype none
module ebs_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic [23:0] acc_addr,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic soft_reset_event,
  input wire logic watchdog_reset_event,
  input wire logic init_end_instruction,
  input wire logic read_strobe_n,
  input wire logic low_byte_store_strobe_n,
  input wire logic address_latch,
  input wire logic [7:0] segment_address_port,
  input wire logic boot_fetch_select,
  input wire logic [2:0] bus_control_port,
  input wire logic boot_external,
  input wire logic [2:0] start_pin_config,
  input wire logic reset_indicator_output_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire start = acc_req && !acc_busy;
  wire [7:0] seg_in = acc_addr[23:16];
  wire pin_rd = bus_control_port[0];
  property p_rd;
    start && (!acc_write || acc_fetch) |-> ##2 !read_strobe_n && low_byte_store_strobe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe missing");
  property p_wr;
    start && acc_write && !acc_fetch |-> ##2 read_strobe_n;
  endproperty
  a_wr: assert property (p_wr) else $error("read strobe on write");
  property p_ale;
    address_latch |-> $past(start) && read_strobe_n ##1 !address_latch;
  endproperty
  a_ale: assert property (p_ale) else $error("latch pulse wrong");
  property p_seg;
    start |=> segment_address_port == $past(seg_in);
  endproperty
  a_seg: assert property (p_seg) else $error("segment wrong");
  property p_done;
    start |-> ##[4:40] acc_done;
  endproperty
  a_done: assert property (p_done) else $error("cycle never ends");
  property p_hw;
    disable iff (1'b0) reset |=> !reset_indicator_output_n;
  endproperty
  a_hw: assert property (p_hw) else $error("indicator idle in reset");
  property p_rel;
    init_end_instruction && !soft_reset_event && !watchdog_reset_event |=> reset_indicator_output_n;
  endproperty
  a_rel: assert property (p_rel) else $error("indicator not released");
  property p_boot;
    $fell(reset) |=> boot_external == !$past(boot_fetch_select) && start_pin_config ==
      ($past(boot_fetch_select) ? $past(bus_control_port) : {2'b00, $past(pin_rd)});
  endproperty
  a_boot: assert property (p_boot) else $error("boot capture wrong");
endmodule : ebs_checker
`default_nettype wire

// File: tb/ebs_mem_model.sv
`default_nettype none
module ebs_mem_model (
  input wire logic clk,
  input wire logic read_strobe_n,
  input wire logic low_byte_store_strobe_n,
  input wire logic [2:0] waits,
  output logic bus_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  wire active = !read_strobe_n || !low_byte_store_strobe_n;
  always_ff @(posedge clk) begin
    cnt <= active ? cnt + 3'h1 : 3'h0;
  end
  // Waits are held for the first cycles of a strobe; an unaddressed device lets the line fall to ready.
  assign bus_ready_n = active ? (cnt < waits) : 1'b0;
endmodule : ebs_mem_model
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
`include "ebs_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic acc_req = 1'b0, acc_write = 1'b0, acc_fetch = 1'b0;
  logic [1:0] acc_byte_en = 2'h0;
  logic [23:0] acc_addr = 24'h0;
  logic soft_reset_event = 1'b0, watchdog_reset_event = 1'b0, init_end_instruction = 1'b0;
  logic boot_fetch_select = 1'b1;
  logic [15:0] multiplexed_bus_port_zero = 16'h0, start_config;
  logic [2:0] bus_control_port = 3'h0, waits = 3'h0, start_pin_config;
  logic acc_busy, acc_done, read_strobe_n, low_byte_store_strobe_n, address_latch, bus_ready_n;
  logic boot_external, reset_indicator_output_n;
  logic [7:0] segment_address_port;
  int miscompares = 0, tests_run = 0, rd_lo = 0, wr_lo = 0, ale_n = 0;
  ebs_bus_ctrl i_ebs_bus_ctrl (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .acc_req, .acc_write, .acc_fetch, .acc_byte_en, .acc_addr, .acc_busy, .acc_done, .soft_reset_event,
    .watchdog_reset_event, .init_end_instruction, .read_strobe_n, .low_byte_store_strobe_n, .address_latch,
    .bus_ready_n, .segment_address_port, .boot_fetch_select, .multiplexed_bus_port_zero, .bus_control_port,
    .boot_external, .start_config, .start_pin_config, .reset_indicator_output_n);
  ebs_mem_model i_ebs_mem_model (.clk, .read_strobe_n, .low_byte_store_strobe_n, .waits, .bus_ready_n);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    rd_lo += int'(!read_strobe_n);
    wr_lo += int'(!low_byte_store_strobe_n);
    ale_n += int'(address_latch);
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, v, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic ev(input logic [2:0] b, input logic e);
    @(posedge clk);
    {soft_reset_event, watchdog_reset_event, init_end_instruction} <= b;
    @(posedge clk);
    {soft_reset_event, watchdog_reset_event, init_end_instruction} <= 3'h0;
    #1 chk("indicator", reset_indicator_output_n, e);
  endtask : ev
  task automatic rst(input logic bfs);
    logic [2:0] p;
    @(posedge clk);
    {reset, boot_fetch_select} <= {1'b1, bfs};
    multiplexed_bus_port_zero <= 16'($urandom);
    bus_control_port <= 3'($urandom);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1 chk("indicator in reset", reset_indicator_output_n, 1'b0);
    @(posedge clk);
    #1 p = bfs ? bus_control_port : {2'b00, bus_control_port[0]};
    chk("boot", boot_external, !bfs);
    chk("config", start_config, bfs ? 16'h0 : multiplexed_bus_port_zero);
    chk("pins", start_pin_config, p);
    rd(`EBS_OFS_STATUS);
    chk("status", d, {26'h0, p, 1'b0, !bfs, 1'b1});
    rd(`EBS_OFS_CONFIG);
    chk("config reg", d, {16'h0, bfs ? 16'h0 : multiplexed_bus_port_zero});
  endtask : rst
  task automatic acc(input logic w, input logic f, input logic [3:0] ctl);
    int n;
    int nw;
    logic rexp;
    logic wexp;
    @(posedge clk);
    {acc_req, acc_write, acc_fetch, acc_byte_en} <= {1'b1, w, f, 2'($urandom)};
    {acc_addr, waits} <= {24'($urandom), 3'($urandom % 4)};
    #1 {rd_lo, wr_lo, ale_n, n} = {32'h0, 32'h0, 32'h0, 32'h0};
    do begin
      @(posedge clk);
      acc_req <= 1'b0;
      #1 n++;
      if (n == 1) chk("busy", acc_busy, 1'b1);
    end while (acc_done !== 1'b1 && n < 50);
    rexp = !w || f;
    wexp = w && !f && (!ctl[0] || ctl[1] || acc_byte_en[0]);
    nw = (ctl[2] && (rexp || wexp)) ? int'(waits) : 0;
    chk("latency", n, 4 + nw);
    chk("idle", acc_busy, 1'b0);
    chk("read strobe", rd_lo, rexp ? 1 + nw : 0);
    chk("write strobe", wr_lo, wexp ? 1 + nw : 0);
    chk("latch", ale_n, ctl[3]);
    chk("segment", segment_address_port, acc_addr[23:16]);
  endtask : acc
  initial begin
    d = $urandom(32'hf96bde86);
    rst(1'b1);
    rd(`EBS_OFS_CTRL);
    chk("ctrl reset", d, 32'(`EBS_CTRL_RESET));
    rd(8'h10);
    chk("unmapped", d, 32'h0);
    ev(3'b001, 1'b1);
    ev(3'b100, 1'b1);
    wr(`EBS_OFS_CTRL, 32'h18);
    ev(3'b010, 1'b0);
    wr(`EBS_OFS_CMD, 32'h1);
    chk("sw release", reset_indicator_output_n, 1'b1);
    ev(3'b101, 1'b0);
    wr(`EBS_OFS_CTRL, 32'h38);
    ev(3'b100, 1'b0);
    @(posedge clk);
    #1 chk("end of soft reset", reset_indicator_output_n, 1'b1);
    for (int m = 0; m < 16; m++) begin
      wr(`EBS_OFS_CTRL, 32'(m));
      rd(`EBS_OFS_CTRL);
      chk("ctrl", d, 32'(m));
      for (int k = 0; k < 6; k++) acc(k[0], k[2], 4'(m));
    end
    rst(1'b0);
    end_of_test;
  end
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule : tb_top
bind ebs_bus_ctrl ebs_checker i_ebs_checker (.clk, .reset, .acc_req, .acc_write, .acc_fetch, .acc_addr,
  .acc_busy, .acc_done, .soft_reset_event, .watchdog_reset_event, .init_end_instruction, .read_strobe_n,
  .low_byte_store_strobe_n, .address_latch, .segment_address_port, .boot_fetch_select, .bus_control_port,
  .boot_external, .start_pin_config, .reset_indicator_output_n);
`default_nettype wire
